// ===== core/storage_message_framer.v
// Overview of operation
// - Control message: channel zero and selector byte
// - Byte one carries the function code
// - Send address: path byte then zero byte
// - One control message per frame only
// - Data field never exceeds 32 bytes
// - Pad with zeros; receiver ignores pad
// - Command may carry two-byte channel field
// - One-byte channel sits first; second ignored
// - Tag sits in bytes two and three
// - Optional logical unit number in byte eight
// - Tags unique across outstanding data tasks
// - Nonzero channel means data frame
// - Datagram delivery; no end-to-end acknowledge
// - Order kept within one logical path
// - Record outstanding tasks for completion mapping
// - Move confirmed tasks to alternate path
// - Configurable port count, one to 127
// - Multi-byte fields most significant first
// - Unknown function code raises alert, dropped
`default_nettype none
`include "msg_framer_regs.vh"

module storage_message_framer (
  input wire core_clk,
  input wire arst_n,
  // Receive stream from transport
  input wire rx_valid,
  input wire rx_sof,
  input wire rx_eof,
  input wire [7:0] rx_chan,
  input wire [7:0] rx_byte,
  input wire [6:0] rx_port,
  // Parsed control message
  output reg msg_valid,
  output reg [7:0] msg_function_code,
  output reg [15:0] msg_tag,
  output reg [31:0] msg_reply_route_id,
  output reg msg_has_lun,
  output reg [7:0] msg_lun,
  output reg msg_has_chan,
  output reg [7:0] msg_chan,
  output reg alert_valid,
  output reg [1:0] alert_kind,
  // Pass-through streams
  output reg data_valid,
  output reg data_sof,
  output reg data_eof,
  output reg [7:0] data_byte,
  output reg other_valid,
  output reg other_sof,
  output reg other_eof,
  output reg [7:0] other_byte,
  // Send request
  input wire tx_req,
  input wire [7:0] tx_function_code,
  input wire [15:0] tx_tag,
  input wire [7:0] tx_path,
  input wire [6:0] tx_port,
  input wire [5:0] tx_len,
  output reg tx_ack,
  output reg tx_err,
  // Send stream to transport
  output reg out_valid,
  output reg out_sof,
  output reg out_eof,
  output reg [7:0] out_byte,
  output reg [6:0] out_port,
  input wire out_ready,
  // Configuration and path control
  input wire [6:0] num_ports,
  input wire confirm_enable,
  input wire path_fail,
  input wire [6:0] fail_port,
  input wire [6:0] alt_port,
  input wire alt_valid,
  output reg sweep_busy
);

  // ----------------------------------------
  // Receive frame classification
  // ----------------------------------------
  localparam [3:0] K_NONE = 4'h1;
  localparam [3:0] K_MSG = 4'h2;
  localparam [3:0] K_OTHER = 4'h4;
  localparam [3:0] K_DATA = 4'h8;

  reg [3:0] kind;
  reg [3:0] next_kind;
  reg [5:0] cnt;
  reg too_long;
  wire [5:0] rx_len = cnt + 6'h01;
  wire [3:0] tbl_hit_addr;
  wire [`TBL_W-1:0] rd_data;

  // Kind of the frame this byte belongs to
  always @* begin
    next_kind = kind;
    if (rx_valid && rx_sof) begin
      if (rx_chan != `CTRL_CHANNEL) begin
        next_kind = K_DATA;
      end else if (rx_byte == `PROTOCOL_SELECTOR) begin
        next_kind = K_MSG;
      end else begin
        next_kind = K_OTHER;
      end
    end
  end

  // Supported function codes at a target
  wire code_ok = msg_function_code == `FC_COMMAND ||
                 msg_function_code == `FC_CONFIRM ||
                 msg_function_code == `FC_ENABLE_AER ||
                 (msg_function_code >= `FC_TM_FIRST &&
                  msg_function_code <= `FC_TM_LAST);

  wire msg_byte = rx_valid && next_kind == K_MSG;
  wire msg_end = msg_byte && rx_eof;
  wire short_msg = rx_len < `MSG_MIN_LEN;
  // Byte 33 onward seen, including the byte on the wire now
  wire long_msg = too_long || cnt >= `MSG_MAX_LEN;
  wire tag_busy = rd_data[`TBL_VALID];
  wire is_cmd = msg_function_code == `FC_COMMAND;
  wire good_end = msg_end && !short_msg && !long_msg && code_ok;
  wire rec_w = good_end && is_cmd && !tag_busy;

  // Frame tracking and field capture
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      kind <= K_NONE;
      cnt <= 6'h00;
      too_long <= 1'b0;
      msg_function_code <= 8'h00;
      msg_tag <= 16'h0000;
      msg_reply_route_id <= 32'h00000000;
      msg_lun <= 8'h00;
      msg_chan <= 8'h00;
    end else begin
      if (rx_valid) begin
        kind <= rx_eof ? K_NONE : next_kind;
        cnt <= rx_eof ? 6'h00 : (rx_sof ? 6'h01 : rx_len);
        too_long <= rx_sof ? 1'b0 :
                    (too_long || cnt >= `MSG_MAX_LEN);
      end
      if (msg_byte && !rx_sof) begin
        if (cnt == `POS_CODE) begin
          msg_function_code <= rx_byte;
        end
        if (cnt == `POS_TAG_HI) begin
          msg_tag[15:8] <= rx_byte;
        end
        if (cnt == `POS_TAG_LO) begin
          msg_tag[7:0] <= rx_byte;
        end
        if (cnt >= `POS_ROUTE0 && cnt <= `POS_ROUTE3) begin
          msg_reply_route_id <= {msg_reply_route_id[23:0], rx_byte};
        end
        if (cnt == `POS_LUN) begin
          msg_lun <= rx_byte;
        end
        if (cnt == `POS_CHAN) begin
          msg_chan <= rx_byte;
        end
      end
    end
  end

  // Message completion and alerts; bytes past defined ones ignored
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      msg_valid <= 1'b0;
      msg_has_lun <= 1'b0;
      msg_has_chan <= 1'b0;
      alert_valid <= 1'b0;
      alert_kind <= `ALERT_UNKNOWN;
    end else begin
      msg_valid <= good_end && !(is_cmd && tag_busy);
      alert_valid <= msg_end && !(good_end && !(is_cmd && tag_busy));
      if (msg_end) begin
        msg_has_lun <= rx_len >= `LUN_MIN_LEN;
        msg_has_chan <= is_cmd && rx_len >= `CHAN_MIN_LEN;
        if (short_msg) begin
          alert_kind <= `ALERT_SHORT;
        end else if (long_msg) begin
          alert_kind <= `ALERT_LONG;
        end else if (!code_ok) begin
          alert_kind <= `ALERT_UNKNOWN;
        end else begin
          alert_kind <= `ALERT_TAG;
        end
      end
    end
  end

  // In-order pass-through of data and foreign frames
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_valid <= 1'b0;
      data_sof <= 1'b0;
      data_eof <= 1'b0;
      data_byte <= 8'h00;
      other_valid <= 1'b0;
      other_sof <= 1'b0;
      other_eof <= 1'b0;
      other_byte <= 8'h00;
    end else begin
      data_valid <= rx_valid && next_kind == K_DATA;
      other_valid <= rx_valid && next_kind == K_OTHER;
      data_sof <= rx_sof;
      data_eof <= rx_eof;
      data_byte <= rx_byte;
      other_sof <= rx_sof;
      other_eof <= rx_eof;
      other_byte <= rx_byte;
    end
  end

  // ----------------------------------------
  // Send path
  // ----------------------------------------
  localparam [3:0] T_IDLE = 4'h1;
  localparam [3:0] T_PATH = 4'h2;
  localparam [3:0] T_CHAN = 4'h4;
  localparam [3:0] T_DATA = 4'h8;

  reg [3:0] tstate;
  reg [5:0] tidx;
  reg [5:0] tlast;
  reg [7:0] t_code;
  reg [15:0] t_tag;
  reg [7:0] t_path;

  wire port_ok = tx_port < num_ports && num_ports != 7'h00;
  wire out_move = !out_valid || out_ready;
  wire tx_take = tx_req && tstate == T_IDLE && !rec_w && out_move;
  wire [5:0] tx_len_c = tx_len > `MSG_MAX_LEN ? `MSG_MAX_LEN :
                        (tx_len < `MSG_MIN_LEN ? `MSG_MIN_LEN : tx_len);
  wire clr_w = tx_take && port_ok &&
               (tx_function_code == `FC_STATUS ||
                tx_function_code == `FC_RESPONSE);
  reg [7:0] data_pick;

  // Data byte by position, zeros beyond the defined bytes
  always @* begin
    data_pick = 8'h00;
    if (tidx == 6'h00) begin
      data_pick = `PROTOCOL_SELECTOR;
    end else if (tidx == `POS_CODE) begin
      data_pick = t_code;
    end else if (tidx == `POS_TAG_HI) begin
      data_pick = t_tag[15:8];
    end else if (tidx == `POS_TAG_LO) begin
      data_pick = t_tag[7:0];
    end
  end

  // Send sequencer: address, then one whole frame of data
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tstate <= T_IDLE;
      tidx <= 6'h00;
      tlast <= 6'h00;
      t_code <= 8'h00;
      t_tag <= 16'h0000;
      t_path <= 8'h00;
      tx_ack <= 1'b0;
      tx_err <= 1'b0;
      out_valid <= 1'b0;
      out_sof <= 1'b0;
      out_eof <= 1'b0;
      out_byte <= 8'h00;
      out_port <= 7'h00;
    end else begin
      tx_ack <= tx_take && port_ok;
      tx_err <= tx_take && !port_ok;
      case (tstate)
        T_IDLE: begin
          if (out_ready) begin
            out_valid <= 1'b0;
          end
          if (tx_take && port_ok && out_move) begin
            t_code <= tx_function_code;
            t_tag <= tx_tag;
            t_path <= tx_path;
            tlast <= tx_len_c - 6'h01;
            out_port <= tx_port;
            tstate <= T_PATH;
          end
        end
        T_PATH: begin
          if (out_move) begin
            out_valid <= 1'b1;
            out_sof <= 1'b1;
            out_eof <= 1'b0;
            out_byte <= t_path;
            tstate <= T_CHAN;
          end
        end
        T_CHAN: begin
          if (out_move) begin
            out_sof <= 1'b0;
            out_byte <= `CTRL_CHANNEL;
            tidx <= 6'h00;
            tstate <= T_DATA;
          end
        end
        T_DATA: begin
          if (out_move) begin
            out_byte <= data_pick;
            out_eof <= tidx == tlast;
            tidx <= tidx + 6'h01;
            if (tidx == tlast) begin
              tstate <= T_IDLE;
            end
          end
        end
        default: begin
          tstate <= T_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Outstanding task record and path failover
  // ----------------------------------------
  reg [3:0] sw_idx;
  reg sw_phase;
  reg [6:0] sw_from;
  reg [6:0] sw_to;

  wire sw_go = sweep_busy && kind != K_MSG && next_kind != K_MSG;
  wire sw_match = rd_data[`TBL_VALID] && rd_data[`TBL_CONF] &&
                  rd_data[22:16] == sw_from;
  wire mv_w = sw_go && sw_phase && sw_match && !rec_w && !clr_w;
  wire sw_step = sw_go && sw_phase && (!sw_match || mv_w);
  wire wr_en = rec_w || clr_w || mv_w;
  reg [3:0] wr_addr;
  reg [`TBL_W-1:0] wr_data;

  assign tbl_hit_addr = sweep_busy && kind != K_MSG ? sw_idx : msg_tag[3:0];

  // Write selection: new task, completion, then failover move
  always @* begin
    wr_addr = msg_tag[3:0];
    wr_data = {1'b1, confirm_enable, rx_port, msg_tag};
    if (!rec_w && clr_w) begin
      wr_addr = tx_tag[3:0];
      wr_data = {`TBL_W{1'b0}};
    end else if (!rec_w) begin
      wr_addr = sw_idx;
      wr_data = {rd_data[24:23], sw_to, rd_data[15:0]};
    end
  end

  // Failover sweep over every entry
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sweep_busy <= 1'b0;
      sw_idx <= 4'h0;
      sw_phase <= 1'b0;
      sw_from <= 7'h00;
      sw_to <= 7'h00;
    end else if (!sweep_busy) begin
      sw_idx <= 4'h0;
      sw_phase <= 1'b0;
      if (path_fail && alt_valid) begin
        sweep_busy <= 1'b1;
        sw_from <= fail_port;
        sw_to <= alt_port;
      end
    end else if (!sw_go) begin
      sw_phase <= 1'b0;
    end else if (!sw_phase) begin
      sw_phase <= 1'b1;
    end else if (sw_step) begin
      sw_phase <= 1'b0;
      sw_idx <= sw_idx + 4'h1;
      if (sw_idx == 4'hf) begin
        sweep_busy <= 1'b0;
      end
    end
  end

  task_table u_table (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(tbl_hit_addr),
    .rd_data(rd_data)
  );

endmodule
`default_nettype wire

// ===== core/msg_framer_regs.vh
`ifndef MSG_FRAMER_REGS_VH
`define MSG_FRAMER_REGS_VH

// ----------------------------------------
// Frame field values
// ----------------------------------------
`define CTRL_CHANNEL 8'h00
`define PROTOCOL_SELECTOR 8'h83
`define MSG_MAX_LEN 6'h20
`define MSG_MIN_LEN 6'h04
`define LUN_MIN_LEN 6'h09
`define CHAN_MIN_LEN 6'h0b

// ----------------------------------------
// Byte positions in the data field
// ----------------------------------------
`define POS_CODE 6'h01
`define POS_TAG_HI 6'h02
`define POS_TAG_LO 6'h03
`define POS_ROUTE0 6'h04
`define POS_ROUTE3 6'h07
`define POS_LUN 6'h08
`define POS_CHAN 6'h09

// ----------------------------------------
// Function codes
// ----------------------------------------
`define FC_RESPONSE 8'h03
`define FC_COMMAND 8'h10
`define FC_STATUS 8'h11
`define FC_CONFIRM 8'h12
`define FC_ENABLE_AER 8'h20
`define FC_TM_FIRST 8'h30
`define FC_TM_LAST 8'h35

// ----------------------------------------
// Alert kinds
// ----------------------------------------
`define ALERT_UNKNOWN 2'h0
`define ALERT_SHORT 2'h1
`define ALERT_LONG 2'h2
`define ALERT_TAG 2'h3

// ----------------------------------------
// Outstanding table layout
// ----------------------------------------
`define TBL_DEPTH 16
`define TBL_AW 4
`define TBL_W 25
`define TBL_VALID 24
`define TBL_CONF 23

`endif

// ===== core/task_table.v
`default_nettype none
`include "msg_framer_regs.vh"

module task_table (
  input wire core_clk,
  input wire arst_n,
  input wire wr_en,
  input wire [`TBL_AW-1:0] wr_addr,
  input wire [`TBL_W-1:0] wr_data,
  input wire [`TBL_AW-1:0] rd_addr,
  output reg [`TBL_W-1:0] rd_data
);

  wire [`TBL_W-1:0] entry [0:`TBL_DEPTH-1];

  // ----------------------------------------
  // Entry storage, cleared at reset
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `TBL_DEPTH; i = i + 1) begin : g_entry
      reg [`TBL_W-1:0] slot;
      // Write one entry
      always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          slot <= {`TBL_W{1'b0}};
        end else if (wr_en && wr_addr == i) begin
          slot <= wr_data;
        end
      end
      assign entry[i] = slot;
    end
  endgenerate

  // Registered read port
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= {`TBL_W{1'b0}};
    end else begin
      rd_data <= entry[rd_addr];
    end
  end

endmodule
`default_nettype wire

// ===== sim/framer_monitor.sv
`default_nettype none
module framer_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic [7:0] rx_chan,
  input wire logic [7:0] rx_byte,
  input wire logic msg_valid,
  input wire logic alert_valid,
  input wire logic data_valid,
  input wire logic data_sof,
  input wire logic [7:0] data_byte,
  input wire logic other_valid,
  input wire logic other_sof,
  input wire logic [7:0] other_byte,
  input wire logic tx_req,
  input wire logic [6:0] tx_port,
  input wire logic [6:0] num_ports,
  input wire logic tx_ack,
  input wire logic tx_err,
  input wire logic out_valid,
  input wire logic out_sof,
  input wire logic out_eof,
  input wire logic [7:0] out_byte,
  input wire logic out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [5:0] ocnt;
  logic bad_port;
  assign bad_port = (tx_port >= num_ports) || (num_ports == 7'h00);
  // Bytes already taken in the current send frame
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) ocnt <= 6'h00;
    else if (out_valid && out_ready) ocnt <= out_eof ? 6'h00 : ocnt + 6'h01;
  end
  AST_END_ONLY: assert property (
    (msg_valid || alert_valid) |-> $past(rx_valid && rx_eof))
    else $error("answer without frame end");
  AST_ONE_ANSWER: assert property (alert_valid |-> !msg_valid)
    else $error("alert and message together");
  AST_DATA_PASS: assert property (
    rx_valid && rx_sof && rx_chan != 8'h00 |=> data_valid && data_sof &&
    data_byte == $past(rx_byte) && !other_valid)
    else $error("data frame not passed");
  AST_OTHER_PASS: assert property (
    rx_valid && rx_sof && rx_chan == 8'h00 && rx_byte != 8'h83 |=>
    other_valid && other_sof && other_byte == $past(rx_byte))
    else $error("foreign frame not passed");
  AST_CTRL_KEPT: assert property (
    rx_valid && rx_sof && rx_chan == 8'h00 && rx_byte == 8'h83 |=>
    !data_valid && !other_valid)
    else $error("control frame leaked");
  AST_ADDR_ZERO: assert property (
    out_valid && out_ready && out_sof |=>
    out_valid && !out_sof && out_byte == 8'h00)
    else $error("no zero channel byte");
  AST_HOLD: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_byte) &&
    $stable(out_eof))
    else $error("send byte dropped in stall");
  AST_MAX_LEN: assert property (out_valid && out_eof |-> ocnt <= 6'h21)
    else $error("send frame too long");
  AST_PORT_REFUSE: assert property (
    tx_err |-> $past(tx_req) && $past(bad_port))
    else $error("send refused wrongly");
  AST_PORT_ACCEPT: assert property (
    tx_ack |-> $past(tx_req) && !$past(bad_port))
    else $error("send accepted wrongly");
endmodule
bind storage_message_framer framer_monitor mon (
  .core_clk(core_clk), .arst_n(arst_n), .rx_valid(rx_valid),
  .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_chan(rx_chan), .rx_byte(rx_byte),
  .msg_valid(msg_valid), .alert_valid(alert_valid),
  .data_valid(data_valid), .data_sof(data_sof), .data_byte(data_byte),
  .other_valid(other_valid), .other_sof(other_sof),
  .other_byte(other_byte), .tx_req(tx_req), .tx_port(tx_port),
  .num_ports(num_ports), .tx_ack(tx_ack), .tx_err(tx_err),
  .out_valid(out_valid), .out_sof(out_sof), .out_eof(out_eof),
  .out_byte(out_byte), .out_ready(out_ready));
`default_nettype wire

// ===== sim/transport_sink.sv
`default_nettype none
module transport_sink (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic out_valid,
  input wire logic out_eof,
  input wire logic [7:0] out_byte,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cap [0:39];
  int cnt;
  logic done;
  initial begin
    out_ready = 1'b0;
    cnt = 0;
    done = 1'b0;
  end
  // Takes whole frames, no acknowledge back; stalls at random when slow
  always @(posedge core_clk) begin
    if (out_valid && out_ready && cnt < 40) begin
      cap[cnt] = out_byte;
      cnt = cnt + 1;
      done = out_eof;
    end
    #5 out_ready = arst_n && (!slow || $urandom_range(0, 2) == 0);
  end
endmodule
`default_nettype wire

// ===== sim/storage_message_framer_test.sv
`default_nettype none
`include "msg_framer_regs.vh"
module storage_message_framer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, arst_n, rx_valid, rx_sof, rx_eof, msg_valid, msg_has_lun;
  logic msg_has_chan, alert_valid, data_valid, data_sof, data_eof;
  logic other_valid, other_sof, other_eof, tx_req, tx_ack, tx_err, slow;
  logic out_valid, out_sof, out_eof, out_ready, confirm_enable, path_fail;
  logic alt_valid, sweep_busy;
  logic [7:0] rx_chan, rx_byte, msg_function_code, msg_lun, msg_chan;
  logic [7:0] data_byte, other_byte, tx_function_code, tx_path, out_byte;
  logic [6:0] rx_port, tx_port, out_port, num_ports, fail_port, alt_port;
  logic [15:0] msg_tag, tx_tag, f_tag;
  logic [31:0] msg_reply_route_id, f_rt;
  logic [1:0] alert_kind;
  logic [5:0] tx_len;
  logic [7:0] f_sel, f_code, f_lun, f_chn;
  logic [7:0] codes [10] = '{8'h12, 8'h20, 8'h30, 8'h31, 8'h32, 8'h33,
                             8'h34, 8'h35, 8'h12, 8'h20};
  int mismatches = 0;
  int compares = 0;
  int n;
  storage_message_framer dut (
    .core_clk(core_clk), .arst_n(arst_n), .rx_valid(rx_valid),
    .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_chan(rx_chan), .rx_byte(rx_byte),
    .rx_port(rx_port), .msg_valid(msg_valid),
    .msg_function_code(msg_function_code), .msg_tag(msg_tag),
    .msg_reply_route_id(msg_reply_route_id), .msg_has_lun(msg_has_lun),
    .msg_lun(msg_lun), .msg_has_chan(msg_has_chan), .msg_chan(msg_chan),
    .alert_valid(alert_valid), .alert_kind(alert_kind),
    .data_valid(data_valid), .data_sof(data_sof), .data_eof(data_eof),
    .data_byte(data_byte), .other_valid(other_valid),
    .other_sof(other_sof), .other_eof(other_eof), .other_byte(other_byte),
    .tx_req(tx_req), .tx_function_code(tx_function_code), .tx_tag(tx_tag),
    .tx_path(tx_path), .tx_port(tx_port), .tx_len(tx_len),
    .tx_ack(tx_ack), .tx_err(tx_err), .out_valid(out_valid),
    .out_sof(out_sof), .out_eof(out_eof), .out_byte(out_byte),
    .out_port(out_port), .out_ready(out_ready), .num_ports(num_ports),
    .confirm_enable(confirm_enable), .path_fail(path_fail),
    .fail_port(fail_port), .alt_port(alt_port), .alt_valid(alt_valid),
    .sweep_busy(sweep_busy));
  transport_sink sink (.core_clk(core_clk), .arst_n(arst_n), .slow(slow),
    .out_valid(out_valid), .out_eof(out_eof), .out_byte(out_byte),
    .out_ready(out_ready));
  // Clock at 20 MHz
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Receive byte at position i, multi-byte fields high byte first
  function automatic logic [7:0] byte_at(input int i);
    case (i)
      0: return f_sel;
      1: return f_code;
      2: return f_tag[15:8];
      3: return f_tag[7:0];
      4: return f_rt[31:24];
      5: return f_rt[23:16];
      6: return f_rt[15:8];
      7: return f_rt[7:0];
      8: return f_lun;
      9: return f_chn;
      default: return 8'ha5;
    endcase
  endfunction
  // Send byte j: path, zero channel, selector, code, tag, zero pad
  function automatic logic [7:0] exp_out(input int j, input logic [7:0] p);
    case (j)
      0: return p;
      1: return 8'h00;
      2: return 8'h83;
      3: return tx_function_code;
      4: return tx_tag[15:8];
      5: return tx_tag[7:0];
      default: return 8'h00;
    endcase
  endfunction
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic rx_frame(input logic [7:0] ch, input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge core_clk) #5;
      rx_valid = 1'b1;
      rx_sof = (i == 0);
      rx_eof = (i == len - 1);
      rx_chan = ch;
      rx_byte = byte_at(i);
    end
    @(posedge core_clk) #5;
    rx_valid = 1'b0;
    rx_eof = 1'b0;
    rx_byte = ~rx_byte;
    rx_chan = ~ch;
  endtask
  task automatic expect_msg(input int len);
    chk("msg_valid", 1, msg_valid);
    chk("code", f_code, msg_function_code);
    chk("tag", f_tag, msg_tag);
    chk("route", f_rt, msg_reply_route_id);
    chk("has_lun", len >= 9, msg_has_lun);
    if (len >= 9) chk("lun", f_lun, msg_lun);
    chk("has_chan", f_code == `FC_COMMAND && len >= 11, msg_has_chan);
    if (len >= 11) chk("chan", f_chn, msg_chan);
  endtask
  task automatic expect_alert(input logic [1:0] kind);
    chk("alert_valid", 1, alert_valid);
    chk("alert_kind", kind, alert_kind);
    chk("msg_valid", 0, msg_valid);
  endtask
  task automatic send(input logic [7:0] c, input logic [15:0] t,
      input logic [6:0] port, input logic [5:0] len, input logic bad);
    logic [7:0] p;
    p = $urandom;
    @(posedge core_clk) #5;
    tx_req = 1'b1;
    tx_function_code = c;
    tx_tag = t;
    tx_path = p;
    tx_port = port;
    tx_len = len;
    sink.cnt = 0;
    sink.done = 1'b0;
    n = 0;
    do begin
      @(posedge core_clk) #1;
      n++;
    end while (tx_ack !== 1'b1 && tx_err !== 1'b1 && n < 20);
    #4 tx_req = 1'b0;
    if (tx_ack !== 1'b1 && tx_err !== 1'b1) begin
      mismatches++;
      conclude();
    end
    chk("tx_err", bad, tx_err);
    chk("tx_ack", !bad, tx_ack);
    n = 0;
    while (!bad && sink.done !== 1'b1 && n < 400) begin
      @(posedge core_clk) #1;
      n++;
    end
    if (!bad && sink.done !== 1'b1) begin
      mismatches++;
      conclude();
    end
    if (!bad) chk("frame_len", len + 2, sink.cnt);
    if (!bad) chk("out_port", port, out_port);
    for (int j = 0; j < sink.cnt && !bad; j++)
      chk("out_byte", exp_out(j, p), sink.cap[j]);
  endtask
  task automatic set_fields(input logic [7:0] c, input logic [15:0] t);
    f_sel = 8'h83;
    f_code = c;
    f_tag = t;
    f_rt = $urandom;
    f_lun = $urandom;
    f_chn = $urandom;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(54271));
    {rx_valid, rx_sof, rx_eof, tx_req, path_fail, alt_valid, slow} = '0;
    {rx_chan, rx_byte, tx_function_code, tx_path, tx_tag, tx_len} = '0;
    {rx_port, tx_port, fail_port, alt_port} = '0;
    num_ports = 7'h04;
    confirm_enable = 1'b1;
    arst_n = 1'b0;
    repeat (16) @(posedge core_clk);
    #5 arst_n = 1'b1;
    rx_port = 7'h02;
    foreach (codes[k]) begin
      set_fields(codes[k], $urandom);
      n = (k == 0) ? 32 : $urandom_range(8, 32);
      rx_frame(8'h00, n);
      expect_msg(n);
    end
    set_fields(8'h7e, 16'h0001);
    rx_frame(8'h00, 8);
    expect_alert(`ALERT_UNKNOWN);
    set_fields(`FC_RESPONSE, 16'h0004);
    rx_frame(8'h00, 8);
    expect_alert(`ALERT_UNKNOWN);
    set_fields(`FC_STATUS, 16'h0002);
    rx_frame(8'h00, 3);
    expect_alert(`ALERT_SHORT);
    rx_frame(8'h00, 33);
    expect_alert(`ALERT_LONG);
    rx_frame(8'h2c, 6);
    chk("data_eof", 1, data_eof);
    chk("data_valid", 1, data_valid);
    chk("data_msg", 0, msg_valid);
    f_sel = 8'h81;
    rx_frame(8'h00, 8);
    chk("other_eof", 1, other_eof);
    chk("other_valid", 1, other_valid);
    chk("other_msg", 0, msg_valid);
    set_fields(`FC_COMMAND, 16'h1235);
    rx_frame(8'h00, 11);
    expect_msg(11);
    set_fields(`FC_COMMAND, 16'h0045);
    rx_frame(8'h00, 9);
    expect_alert(`ALERT_TAG);
    slow = 1'b1;
    send(`FC_STATUS, 16'h1235, 7'h01, 6'h04, 1'b0);
    rx_frame(8'h00, 9);
    expect_msg(9);
    @(posedge core_clk) #5;
    {path_fail, fail_port, alt_port, alt_valid} = {1'b1, 7'h02, 7'h03, 1'b1};
    @(posedge core_clk) #5;
    path_fail = 1'b0;
    n = 0;
    while (sweep_busy !== 1'b1 && n < 10) begin
      @(posedge core_clk) #1;
      n++;
    end
    chk("sweep_start", 1, sweep_busy);
    n = 0;
    while (sweep_busy !== 1'b0 && n < 200) begin
      @(posedge core_clk) #1;
      n++;
    end
    chk("sweep_end", 0, sweep_busy);
    chk("moved_port", 7'h03, dut.u_table.g_entry[5].slot[22:16]);
    repeat (4) begin
      slow = $urandom;
      send(codes[$urandom_range(0, 9)], $urandom, $urandom_range(0, 3),
           $urandom_range(4, 32), 1'b0);
    end
    send(`FC_RESPONSE, 16'h0003, 7'h04, 6'h04, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
